// ### design/fssr_pkg.sv
package fssr_pkg;

  // Command codes of the status registers
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT     = 8'h7A;
  localparam logic [7:0] CMD_IOUT     = 8'h7B;
  localparam logic [7:0] CMD_INPUT    = 8'h7C;

  // Summary word bit positions
  localparam int SW_VOUT  = 15;
  localparam int SW_IOUT  = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR   = 12;
  localparam int SW_PGN   = 11;
  localparam int SW_OFF   = 6;
  localparam int SW_VOV   = 5;
  localparam int SW_IOC   = 4;
  localparam int SW_VUV   = 3;
  localparam int SW_TEMP  = 2;
  localparam int SW_CML   = 1;
  localparam int SW_OTHER = 0;

  // Detail register bit positions
  localparam int VO_OV  = 7;
  localparam int VO_UV  = 4;
  localparam int VO_MAX = 3;
  localparam int IO_OC  = 7;
  localparam int IO_OCUV = 6;
  localparam int IO_SHR = 3;
  localparam int IN_OV  = 7;
  localparam int IN_UV  = 3;
  localparam int IN_OC  = 2;

  localparam int          NPAGE     = 2;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // Per-output fault events from the regulator
  typedef struct packed {
    logic vout_ov;
    logic vout_uv;
    logic vout_max;
    logic iout_oc;
    logic iout_ocuv;
    logic iout_share;
    logic off;
    logic pgood_n;
  } fssr_rail_s;

  // Global events
  typedef struct packed {
    logic vin_ov;
    logic vin_uv;
    logic vin_oc;
    logic vin_above_uv;
    logic temp;
    logic cml;
    logic mfr;
    logic other;
  } fssr_glob_s;

endpackage : fssr_pkg

// ### design/fssr_top.sv
// Behaviour
// - Command 79h returns a global read-only 16-bit summary covering both outputs.
// - Summary low byte equals the one-byte summary at command 78h.
// - Bit 15 flags any output voltage fault.
// - Bit 14 flags any output current fault.
// - Bit 13 flags any input fault.
// - Bit 12 flags a manufacturer-specific event.
// - Bit 11 set while power-good is negated.
// - Bit 6 set whenever an output is not delivering power.
// - Bit 5 on output overvoltage, bit 4 on output overcurrent.
// - Bit 3 on input undervoltage fault.
// - Bit 2 on temperature event, bit 1 on communication/memory/logic fault.
// - Bit 0 on any other status change.
// - Command 7Ah returns per-page output voltage fault byte.
// - Voltage byte: bit 7 overvoltage, bit 4 undervoltage, bit 3 as below, others unused.
// - Voltage byte bit 3 flags maximum voltage warning.
// - Command 7Bh returns per-page output current fault byte.
// - Current byte: bit 7 overcurrent, bit 6 overcurrent with undervoltage.
// - Current byte bit 3 flags current share fault; others unused.
// - Command 7Ch returns a global input fault byte.
// - Input byte: bit 7 overvoltage, bit 3 undervoltage, bit 2 overcurrent, others unused.
// - Input undervoltage masked until input first rises above threshold.
module fssr_top
  import fssr_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   page,
  input  wire logic [7:0]             cmd_code,
  input  fssr_rail_s [NPAGE-1:0]      rail_ev,
  input  fssr_glob_s                  glob_ev,
  output logic [15:0]                 rd_data,
  output logic                        rd_hit
);

  // Two-stage synchronisers for the asynchronous fault inputs
  fssr_rail_s [NPAGE-1:0] rail_m_ff;
  fssr_rail_s [NPAGE-1:0] rail_s_ff;
  fssr_glob_s             glob_m_ff;
  fssr_glob_s             glob_s_ff;
  logic [7:0]             vout_ff [NPAGE];
  logic [7:0]             iout_ff [NPAGE];
  logic [7:0]             input_ff;
  logic                   uv_armed_ff;
  logic [15:0]            word_ff;
  logic [15:0]            nxt_word;
  logic [7:0]             nxt_input;
  logic [15:0]            nxt_rd_data;
  logic                   nxt_rd_hit;

  // Documented bits of each byte and of the summary word; every other bit reads zero
  localparam logic [7:0]  VO_USED = (8'h01 << VO_OV) | (8'h01 << VO_UV) | (8'h01 << VO_MAX);
  localparam logic [7:0]  IO_USED = (8'h01 << IO_OC) | (8'h01 << IO_OCUV) | (8'h01 << IO_SHR);
  localparam logic [7:0]  IN_USED = (8'h01 << IN_OV) | (8'h01 << IN_UV) | (8'h01 << IN_OC);
  localparam logic [15:0] SW_USED = (16'h0001 << SW_VOUT) | (16'h0001 << SW_IOUT) | (16'h0001 << SW_INPUT)
                                  | (16'h0001 << SW_MFR) | (16'h0001 << SW_PGN) | (16'h0001 << SW_OFF)
                                  | (16'h0001 << SW_VOV) | (16'h0001 << SW_IOC) | (16'h0001 << SW_VUV)
                                  | (16'h0001 << SW_TEMP) | (16'h0001 << SW_CML) | (16'h0001 << SW_OTHER);

  // Both synchroniser stages; only the second stage feeds logic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rail_m_ff <= '0;
      rail_s_ff <= '0;
      glob_m_ff <= '0;
      glob_s_ff <= '0;
    end else begin
      rail_m_ff <= rail_ev;
      rail_s_ff <= rail_m_ff;
      glob_m_ff <= glob_ev;
      glob_s_ff <= glob_m_ff;
    end
  end

  // Per-page detail bytes, unused bits held at zero
  logic [NPAGE-1:0] any_v;
  logic [NPAGE-1:0] any_i;
  logic [NPAGE-1:0] ov_p;
  logic [NPAGE-1:0] oc_p;
  logic [NPAGE-1:0] off_p;
  logic [NPAGE-1:0] pgn_p;
  genvar g;
  generate
    for (g = 0; g < NPAGE; g++) begin : g_page
      logic [7:0] nxt_vout;
      logic [7:0] nxt_iout;
      // Detail bytes rebuilt from the synchronised events
      always_comb begin
        nxt_vout = RST_BYTE;
        nxt_vout[VO_OV]  = rail_s_ff[g].vout_ov;
        nxt_vout[VO_UV]  = rail_s_ff[g].vout_uv;
        nxt_vout[VO_MAX] = rail_s_ff[g].vout_max;
        nxt_iout = RST_BYTE;
        nxt_iout[IO_OC]   = rail_s_ff[g].iout_oc;
        nxt_iout[IO_OCUV] = rail_s_ff[g].iout_ocuv;
        nxt_iout[IO_SHR]  = rail_s_ff[g].iout_share;
      end
      // Per-page detail registers
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          vout_ff[g] <= RST_BYTE;
          iout_ff[g] <= RST_BYTE;
        end else begin
          vout_ff[g] <= nxt_vout;
          iout_ff[g] <= nxt_iout;
        end
      end
      // Page contributions to the summary word
      assign any_v[g] = |vout_ff[g];
      assign any_i[g] = |iout_ff[g];
      assign ov_p[g]  = vout_ff[g][VO_OV];
      assign oc_p[g]  = iout_ff[g][IO_OC];
      assign off_p[g] = rail_s_ff[g].off;
      assign pgn_p[g] = rail_s_ff[g].pgood_n;
    end
  endgenerate

  // Undervoltage arming: latched once input rises above threshold
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      uv_armed_ff <= 1'b0;
    end else if (glob_s_ff.vin_above_uv) begin
      uv_armed_ff <= 1'b1;
    end
  end

  // Global input fault byte
  always_comb begin
    nxt_input = RST_BYTE;
    nxt_input[IN_OV] = glob_s_ff.vin_ov;
    nxt_input[IN_OC] = glob_s_ff.vin_oc;
    nxt_input[IN_UV] = glob_s_ff.vin_uv & uv_armed_ff;
  end

  // Summary word built from the detail registers, and for bits 12, 11, 6, 2, 1 and 0 from the synchronised events
  always_comb begin
    nxt_word = RST_WORD;
    nxt_word[SW_VOUT]  = |any_v;
    nxt_word[SW_IOUT]  = |any_i;
    nxt_word[SW_INPUT] = |input_ff;
    nxt_word[SW_MFR]   = glob_s_ff.mfr;
    nxt_word[SW_PGN]   = |pgn_p;
    nxt_word[SW_OFF]   = |off_p;
    nxt_word[SW_VOV]   = |ov_p;
    nxt_word[SW_IOC]   = |oc_p;
    nxt_word[SW_VUV]   = input_ff[IN_UV];
    nxt_word[SW_TEMP]  = glob_s_ff.temp;
    nxt_word[SW_CML]   = glob_s_ff.cml;
    nxt_word[SW_OTHER] = glob_s_ff.other;
  end

  // Input byte and summary word registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_ff <= RST_BYTE;
      word_ff  <= RST_WORD;
    end else begin
      input_ff <= nxt_input;
      word_ff  <= nxt_word;
    end
  end

  // Read decode by command code and page
  wire         sel_pg = page;
  wire  [7:0]  v_sel  = vout_ff[sel_pg];
  wire  [7:0]  i_sel  = iout_ff[sel_pg];
  always_comb begin
    nxt_rd_hit  = 1'b1;
    nxt_rd_data = RST_WORD;
    unique case (cmd_code)
      CMD_SUM_WORD: nxt_rd_data = word_ff;
      CMD_SUM_BYTE: nxt_rd_data = {RST_BYTE, word_ff[7:0]};
      CMD_VOUT:     nxt_rd_data = {RST_BYTE, v_sel};
      CMD_IOUT:     nxt_rd_data = {RST_BYTE, i_sel};
      CMD_INPUT:    nxt_rd_data = {RST_BYTE, input_ff};
      default:      nxt_rd_hit  = 1'b0;
    endcase
  end

  // Registered answer; stands while the code is held
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= RST_WORD;
      rd_hit  <= 1'b0;
    end else begin
      rd_data <= nxt_rd_data;
      rd_hit  <= nxt_rd_hit;
    end
  end

  // Read path checks; the first edge after any reset is skipped since the answer is still cleared
  a_low_byte_same: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) == CMD_SUM_BYTE |-> rd_hit && rd_data == {RST_BYTE, $past(word_ff[7:0])})
    else $error("byte summary differs from word low byte");
  a_word_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) == CMD_SUM_WORD |-> rd_hit && rd_data == $past(word_ff))
    else $error("summary word read wrong");
  a_vout_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) == CMD_VOUT |-> rd_hit && rd_data == {RST_BYTE, $past(v_sel)})
    else $error("voltage byte read wrong");
  a_iout_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) == CMD_IOUT |-> rd_hit && rd_data == {RST_BYTE, $past(i_sel)})
    else $error("current byte read wrong");
  a_input_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) == CMD_INPUT |-> rd_hit && rd_data == {RST_BYTE, $past(input_ff)})
    else $error("input byte read wrong");
  a_hit_status: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(cmd_code) >= CMD_SUM_BYTE && $past(cmd_code) <= CMD_INPUT |-> rd_hit)
    else $error("status code not answered");
  a_unknown_refused: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && ($past(cmd_code) < CMD_SUM_BYTE || $past(cmd_code) > CMD_INPUT)
      |-> !rd_hit && rd_data == RST_WORD)
    else $error("unknown code answered");

  // Detail byte checks
  a_vout_unused_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    ((vout_ff[0] | vout_ff[1]) & ~VO_USED) == RST_BYTE)
    else $error("unused vout bits set");
  a_iout_unused_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    ((iout_ff[0] | iout_ff[1]) & ~IO_USED) == RST_BYTE)
    else $error("unused iout bits set");
  a_input_unused_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (input_ff & ~IN_USED) == RST_BYTE)
    else $error("unused input bits set");
  a_vmax_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    vout_ff[0][VO_MAX] == $past(rail_s_ff[0].vout_max))
    else $error("voltage maximum warning not captured");
  a_vuv_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    vout_ff[1][VO_UV] == $past(rail_s_ff[1].vout_uv))
    else $error("output undervoltage not captured");
  a_oc_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    iout_ff[1][IO_OC] == $past(rail_s_ff[1].iout_oc) && iout_ff[1][IO_OCUV] == $past(rail_s_ff[1].iout_ocuv))
    else $error("overcurrent bits not captured");
  a_share_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    iout_ff[1][IO_SHR] == $past(rail_s_ff[1].iout_share))
    else $error("current share fault not captured");
  a_input_ov_oc: assert property (@(posedge core_clk) disable iff (!rstn)
    {input_ff[IN_OV], input_ff[IN_OC]} == $past({glob_s_ff.vin_ov, glob_s_ff.vin_oc}))
    else $error("input over bits not captured");
  a_uv_masked_early: assert property (@(posedge core_clk) disable iff (!rstn)
    !uv_armed_ff |=> !input_ff[IN_UV])
    else $error("input uv not masked");
  a_uv_passes_armed: assert property (@(posedge core_clk) disable iff (!rstn)
    uv_armed_ff && glob_s_ff.vin_uv |=> input_ff[IN_UV])
    else $error("armed input uv not reported");
  a_uv_arm_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    uv_armed_ff |=> uv_armed_ff)
    else $error("undervoltage arm dropped");

  // Summary word checks; overvoltage walks detail byte, then summary word
  sequence s_ov_synced;
    rail_s_ff[0].vout_ov;
  endsequence
  sequence s_ov_reported;
    ##1 vout_ff[0][VO_OV] ##1 word_ff[SW_VOV];
  endsequence
  a_ov_follows: assert property (@(posedge core_clk) disable iff (!rstn)
    s_ov_synced |-> s_ov_reported)
    else $error("overvoltage not summarised");
  a_oc_summary: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_IOC] == $past(|oc_p))
    else $error("overcurrent summary bit wrong");
  a_vout_or_pages: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_VOUT] == $past(|any_v))
    else $error("vout summary not OR of pages");
  a_iout_or_pages: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_IOUT] == $past(|any_i))
    else $error("iout summary not OR of pages");
  a_input_summary: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_INPUT] == $past(|input_ff))
    else $error("input summary bit wrong");
  a_uv_summary: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_VUV] == $past(input_ff[IN_UV]))
    else $error("input uv summary bit wrong");
  a_mfr_bit: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_MFR] == $past(glob_s_ff.mfr))
    else $error("specific event bit wrong");
  a_pgood_bit: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_PGN] == $past(|pgn_p))
    else $error("power good bit wrong");
  a_off_follows: assert property (@(posedge core_clk) disable iff (!rstn)
    rail_s_ff[1].off |=> word_ff[SW_OFF])
    else $error("off bit missing");
  a_off_bit: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_OFF] == $past(|off_p))
    else $error("off bit wrong");
  a_temp_cml_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    {word_ff[SW_TEMP], word_ff[SW_CML]} == $past({glob_s_ff.temp, glob_s_ff.cml}))
    else $error("temperature or logic bit wrong");
  a_other_bit: assert property (@(posedge core_clk) disable iff (!rstn)
    word_ff[SW_OTHER] == $past(glob_s_ff.other))
    else $error("other change bit wrong");
  a_word_unused: assert property (@(posedge core_clk) disable iff (!rstn)
    (word_ff & ~SW_USED) == RST_WORD)
    else $error("unused summary bits set");

endmodule : fssr_top

// ### bench/fssr_host_model.sv
// Status-reading host on the management link side
module fssr_host_model
  import fssr_pkg::*;
(
  input  wire logic        core_clk,
  output logic             page,
  output logic [7:0]       cmd_code,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle code outside the status range
  initial begin
    page     = 1'b0;
    cmd_code = 8'h00;
  end

  // Code held until the registered answer settles
  task automatic rd(input logic [7:0] c, input logic p, output logic [16:0] v);
    @(negedge core_clk);
    cmd_code = c;
    page     = p;
    repeat (2) @(negedge core_clk);
    v = {rd_hit, rd_data};
  endtask : rd
endmodule : fssr_host_model

// ### bench/fssr_top_bench.sv
module fssr_top_bench
  import fssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  core_clk = 1'b0;
  logic                  rstn     = 1'b0;
  logic                  page;
  logic [7:0]            cmd_code;
  fssr_rail_s [NPAGE-1:0] rail_ev = '0;
  fssr_glob_s            glob_ev = '0;
  logic [15:0]           rd_data;
  logic                  rd_hit;
  int                    err_count = 0;
  int                    n_checks  = 0;
  int                    cyc       = 0;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  fssr_top fssr_top_i (.core_clk(core_clk), .rstn(rstn), .page(page), .cmd_code(cmd_code),
    .rail_ev(rail_ev), .glob_ev(glob_ev), .rd_data(rd_data), .rd_hit(rd_hit));

  fssr_host_model fssr_host_model_i (.core_clk(core_clk), .page(page), .cmd_code(cmd_code),
    .rd_data(rd_data), .rd_hit(rd_hit));

  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Read one code and compare {hit, data}
  task automatic rdchk(input logic [7:0] c, input logic p, input logic [16:0] exp);
    logic [16:0] v;
    fssr_host_model_i.rd(c, p, v);
    chk(v, exp);
  endtask : rdchk

  // Let events pass through the sync and detail stages
  task automatic settle;
    repeat (8) @(negedge core_clk);
  endtask : settle

  task automatic clr;
    @(negedge core_clk);
    rail_ev = '0;
    glob_ev = '0;
    settle();
  endtask : clr

  task automatic t_idle;
    for (int c = 8'h78; c <= 8'h7C; c++) rdchk(c[7:0], 1'b0, 17'h10000);
    rdchk(8'h7D, 1'b0, 17'h00000);
    rdchk(8'h77, 1'b0, 17'h00000);
  endtask : t_idle

  task automatic t_vout;
    rail_ev[0].vout_ov  = 1'b1;
    rail_ev[0].vout_max = 1'b1;
    settle();
    rdchk(CMD_VOUT, 1'b0, 17'h10088);
    rdchk(CMD_VOUT, 1'b1, 17'h10000);
    rdchk(CMD_SUM_WORD, 1'b1, 17'h18020);
    rdchk(CMD_SUM_BYTE, 1'b0, 17'h10020);
    @(negedge core_clk);
    rail_ev[0] = '0;
    rail_ev[1].vout_uv = 1'b1;
    settle();
    rdchk(CMD_VOUT, 1'b1, 17'h10010);
    rdchk(CMD_SUM_WORD, 1'b0, 17'h18000);
    clr();
  endtask : t_vout

  task automatic t_iout;
    rail_ev[1].iout_oc    = 1'b1;
    rail_ev[1].iout_ocuv  = 1'b1;
    rail_ev[1].iout_share = 1'b1;
    settle();
    rdchk(CMD_IOUT, 1'b1, 17'h100C8);
    rdchk(CMD_IOUT, 1'b0, 17'h10000);
    rdchk(CMD_SUM_WORD, 1'b0, 17'h14010);
    clr();
  endtask : t_iout

  task automatic t_input;
    glob_ev.vin_uv = 1'b1;
    settle();
    rdchk(CMD_INPUT, 1'b0, 17'h10000);
    glob_ev.vin_above_uv = 1'b1;
    settle();
    glob_ev.vin_above_uv = 1'b0;
    settle();
    rdchk(CMD_INPUT, 1'b1, 17'h10008);
    rdchk(CMD_SUM_WORD, 1'b0, 17'h12008);
    glob_ev.vin_ov = 1'b1;
    glob_ev.vin_oc = 1'b1;
    settle();
    rdchk(CMD_INPUT, 1'b0, 17'h1008C);
    // Reset in mid-run: the arm is lost, so undervoltage is masked again
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    settle();
    rdchk(CMD_INPUT, 1'b0, 17'h10084);
    rdchk(CMD_SUM_WORD, 1'b0, 17'h12000);
    clr();
  endtask : t_input

  task automatic t_misc;
    rail_ev[1].off     = 1'b1;
    rail_ev[0].pgood_n = 1'b1;
    glob_ev.temp  = 1'b1;
    glob_ev.cml   = 1'b1;
    glob_ev.mfr   = 1'b1;
    glob_ev.other = 1'b1;
    settle();
    rdchk(CMD_SUM_WORD, 1'b0, 17'h11847);
    rdchk(CMD_SUM_BYTE, 1'b1, 17'h10047);
    clr();
  endtask : t_misc

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    t_idle();
    t_vout();
    t_iout();
    t_input();
    t_misc();
    stop_test();
  end
endmodule : fssr_top_bench
